// File: dv/sfdpr_host.sv
// Serial host model that runs parameter read frames on the link.
// Assumes mode 0: the clock idles low and runs only inside a frame.
`timescale 1ns/1ps
module sfdpr_host (
	output logic sclk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	logic [7:0] rx [0:31];
	logic saw_oe;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
		saw_oe = 1'b0;
	end
	// The start is offset by a fraction of a nanosecond so link edges never meet reference edges.
	task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input int nbits);
		logic [39:0] sh;
		int i;
		sh = {cmd, addr, 8'h00};
		saw_oe = 1'b0;
		#0.3;
		cs_n_o = 1'b0;
		#32;
		for (i = 0; i < 40 + nbits; i++) begin
			mosi_o = (i < 40) ? sh[39 - i] : ~mosi_o;
			#32;
			sclk_o = 1'b1;
			saw_oe = saw_oe | miso_oe_i;
			// A released line reads as the inverse, so undriven bits never match by luck.
			if (i >= 40) rx[(i - 40) / 8] = {rx[(i - 40) / 8][6:0],
				miso_oe_i ? miso_i : ~miso_i};
			#32;
			sclk_o = 1'b0;
		end
		#32;
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
	endtask : frame
endmodule : sfdpr_host

// File: dv/sfdpr_monitor.sv
// Concurrent checks on the ports of the parameter read block.
// Assumes the serial clock runs only while chip select is low.
`timescale 1ns/1ps
module sfdpr_monitor #(
	parameter int unsigned CNT_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire sfdpr_pkg::sfdpr_link_in_s link_i,
	input wire sfdpr_pkg::sfdpr_link_out_s link_o,
	input wire logic param_en_i,
	input wire logic err_clr_i,
	input wire sfdpr_pkg::sfdpr_status_s status_o
);
	logic frame_off;
	logic [5:0] edge_cnt_ff;
	logic [7:0] cmd_ff;
	// Frame tracking is cleared the way the block clears its own state.
	assign frame_off = rst_i | link_i.cs_n;
	always_ff @(posedge sclk_i or posedge frame_off) begin
		if (frame_off) edge_cnt_ff <= 6'h00;
		else if (edge_cnt_ff != 6'h3F) edge_cnt_ff <= edge_cnt_ff + 6'h01;
	end
	always_ff @(posedge sclk_i or posedge frame_off) begin
		if (frame_off) cmd_ff <= 8'h00;
		else if (edge_cnt_ff < 6'h08) cmd_ff <= {cmd_ff[6:0], link_i.mosi};
	end
	sequence s_cmd_done;
		edge_cnt_ff == 6'h28 && cmd_ff == sfdpr_pkg::CMD_READ_PARAM && param_en_i;
	endsequence
	oe_dummy_a: assert property (@(posedge sclk_i) disable iff (frame_off)
		edge_cnt_ff < 6'h28 |-> !link_o.miso_oe) else $error("output enabled early");
	oe_start_a: assert property (@(posedge sclk_i) disable iff (frame_off)
		s_cmd_done |-> link_o.miso_oe) else $error("data output missing");
	refuse_out_a: assert property (@(posedge sclk_i) disable iff (frame_off)
		edge_cnt_ff >= 6'h28 && (cmd_ff != sfdpr_pkg::CMD_READ_PARAM || !param_en_i)
		|-> !link_o.miso_oe) else $error("output on refused command");
	oe_hold_a: assert property (@(posedge sclk_i) disable iff (frame_off)
		edge_cnt_ff > 6'h28 |-> !$fell(link_o.miso_oe)) else $error("output dropped in frame");
	miso_stable_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sclk_i && $past(sclk_i) && !link_i.cs_n && !$past(link_i.cs_n) |-> $stable(link_o.miso))
		else $error("data changed while clock high");
	cs_release_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		link_i.cs_n |-> !link_o.miso_oe && !link_o.miso) else $error("driving while deselected");
	pulse_once_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		status_o.byte_pulse |=> !status_o.byte_pulse) else $error("byte pulse too long");
	count_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		status_o.byte_count == $past(status_o.byte_count) + CNT_W'(status_o.byte_pulse))
		else $error("byte count out of step");
endmodule : sfdpr_monitor

// File: dv/sfdpr_top_tb.sv
// Self-checking bench for the parameter read block driven by the host model.
// Assumes the host model and the checker are compiled before this file.
`timescale 1ns/1ps
module sfdpr_top_tb;
	localparam logic [7:0] MFR = 8'h3C; // Arbitrary maker code.
	localparam logic [7:0] HDR [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h01, 8'h01, 8'h00,
		8'hFF, MFR, 8'h00, 8'h01, 8'h04, 8'h80, 8'h00, 8'h00, 8'hFF, MFR, 8'h00, 8'h01, 8'h00,
		8'h90, 8'h00, 8'h00, 8'hFF};
	localparam logic [7:0] BASIC [0:15] = '{8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'h01, 8'h44, 8'hEB, 8'h08, 8'h6B, 8'h08, 8'h3B, 8'h80, 8'hBB};
	logic ref_clk;
	logic rst;
	logic param_en;
	logic err_clr;
	logic sclk;
	logic cs_n;
	logic mosi;
	sfdpr_pkg::sfdpr_link_in_s link_in;
	sfdpr_pkg::sfdpr_link_out_s link_out;
	sfdpr_pkg::sfdpr_status_s status;
	int bad_count;
	int checks;
	assign link_in = {cs_n, mosi};
	sfdpr_top #(.MFR_ID(MFR), .CNT_W(16)) uut (.ref_clk_i(ref_clk), .rst_i(rst), .sclk_i(sclk),
		.link_i(link_in), .link_o(link_out), .param_en_i(param_en), .err_clr_i(err_clr),
		.status_o(status));
	sfdpr_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(link_out.miso),
		.miso_oe_i(link_out.miso_oe));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize
	function automatic logic [7:0] exp_byte(input logic [10:0] a);
		if (a < 11'h018) return HDR[a[4:0]];
		if (a >= 11'h080 && a < 11'h090) return BASIC[a[3:0]];
		return 8'hFF;
	endfunction : exp_byte
	task automatic rd(input logic [23:0] addr, input int n);
		int k;
		host.frame(8'h5A, addr, n * 8);
		for (k = 0; k < n; k++) check(host.rx[k], exp_byte(addr[10:0] + 11'(k)));
		repeat (8) @(posedge ref_clk);
		check(status.last_frame_bytes, 16'(n));
		check(status.start_addr, addr);
		check(status.active, 1'b0);
	endtask : rd
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		#500_000;
		bad_count++;
		summarize();
	end
	initial begin
		rst = 1'b1;
		param_en = 1'b1;
		err_clr = 1'b0;
		bad_count = 0;
		checks = 0;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		check(link_out.miso_oe, 1'b0);
		rd(24'h00_0000, 24);
		rd(24'h00_007E, 20);
		rd(24'h00_07FF, 2);
		rd(24'hFF_A8F0, 3);
		host.frame(8'h5A, 24'h00_0000, 3);
		@(posedge ref_clk);
		check(link_out.miso_oe, 1'b0);
		rd(24'h00_0003, 2);
		host.frame(8'h03, 24'h00_0000, 16);
		check(host.saw_oe, 1'b0);
		repeat (8) @(posedge ref_clk);
		check(status.bad_cmd, 1'b1);
		err_clr <= 1'b1;
		@(posedge ref_clk);
		err_clr <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(status.bad_cmd, 1'b0);
		param_en <= 1'b0;
		repeat (8) @(posedge ref_clk);
		host.frame(8'h5A, 24'h00_0000, 16);
		check(host.saw_oe, 1'b0);
		param_en <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check(status.bad_cmd, 1'b1);
		check(status.frame_count, 16'h0008);
		check(status.byte_count, 16'h0033);
		check(status.start_addr, 24'h00_0003);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check(status.frame_count, 16'h0000);
		check(status.bad_cmd, 1'b0);
		check(status.byte_count, 16'h0000);
		summarize();
	end
endmodule : sfdpr_top_tb
bind sfdpr_top sfdpr_monitor #(.CNT_W(CNT_W)) u_mon (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.sclk_i(sclk_i), .link_i(link_i), .link_o(link_o), .param_en_i(param_en_i),
	.err_clr_i(err_clr_i), .status_o(status_o));

// File: rtl/sfdpr_pkg.sv
// Constants, types and table contents for the discoverable-parameter read block.
// Assumes a single-bit serial link framed by an active-low chip select.
package sfdpr_pkg;

	// Size of the parameter space and the width of an index into it.
	localparam int unsigned SPACE_BYTES = 2048;
	localparam int unsigned SPACE_AW = $clog2(SPACE_BYTES);

	// Command framing.
	localparam logic [7:0] CMD_READ_PARAM = 8'h5A;
	localparam int unsigned CMD_BITS = 8;
	localparam int unsigned ADDR_BITS = 24;
	localparam int unsigned DUMMY_CYCLES = 8;
	localparam int unsigned PHASE_CNT_W = 5;
	localparam logic [PHASE_CNT_W-1:0] CMD_LAST = PHASE_CNT_W'(CMD_BITS - 1);
	localparam logic [PHASE_CNT_W-1:0] ADDR_LAST = PHASE_CNT_W'(ADDR_BITS - 1);
	localparam logic [PHASE_CNT_W-1:0] DUMMY_LAST = PHASE_CNT_W'(DUMMY_CYCLES - 1);
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

	// Value of every byte that was never factory written.
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// Placement of the factory-written regions.
	localparam logic [SPACE_AW-1:0] HDR_BASE = 11'h000;
	localparam int unsigned HDR_LEN = 24;
	localparam logic [SPACE_AW-1:0] PH0_MFR_ADDR = 11'h008;
	localparam logic [SPACE_AW-1:0] PH1_MFR_ADDR = 11'h010;
	localparam logic [SPACE_AW-1:0] BASIC_BASE = 11'h080;
	localparam int unsigned BASIC_LEN = 16;

	// Table header and both parameter headers; the maker slots are filled in the table module.
	localparam logic [7:0] HDR_BYTES [0:HDR_LEN-1] = '{
		8'h53, 8'h46, 8'h44, 8'h50, 8'h01, 8'h01, 8'h00, 8'hFF,
		8'h00, 8'h00, 8'h01, 8'h04, 8'h80, 8'h00, 8'h00, 8'hFF,
		8'h00, 8'h00, 8'h01, 8'h00, 8'h90, 8'h00, 8'h00, 8'hFF
	};

	// Basic capability table.
	localparam logic [7:0] BASIC_BYTES [0:BASIC_LEN-1] = '{
		8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01,
		8'h44, 8'hEB, 8'h08, 8'h6B, 8'h08, 8'h3B, 8'h80, 8'hBB
	};

	// Status counter width and reset values.
	localparam int unsigned STAT_CNT_W = 16;
	localparam logic [STAT_CNT_W-1:0] STAT_CNT_RST = 16'h0000;
	localparam logic [ADDR_BITS-1:0] START_ADDR_RST = 24'h00_0000;

	// Positions of the levels that cross from the link domain into the reference domain.
	localparam int unsigned XS_ACTIVE = 0;
	localparam int unsigned XS_BAD = 1;
	localparam int unsigned XS_TGL = 2;
	localparam int unsigned XS_CS = 3;
	localparam int unsigned XS_W = 4;

	typedef enum logic [2:0] {
		PH_CMD,
		PH_ADDR,
		PH_DUMMY,
		PH_DATA,
		PH_IGNORE
	} sfdpr_phase_e;

	typedef struct packed {
		logic cs_n;
		logic mosi;
	} sfdpr_link_in_s;

	typedef struct packed {
		logic miso;
		logic miso_oe;
	} sfdpr_link_out_s;

	typedef struct packed {
		logic active;
		logic byte_pulse;
		logic bad_cmd;
		logic [ADDR_BITS-1:0] start_addr;
		logic [STAT_CNT_W-1:0] byte_count;
		logic [STAT_CNT_W-1:0] frame_count;
		logic [STAT_CNT_W-1:0] last_frame_bytes;
	} sfdpr_status_s;

endpackage : sfdpr_pkg

// File: rtl/sfdpr_rom.sv
// Factory parameter table: a combinational lookup of one byte by address.
// Assumes the caller registers the byte before it leaves the chip.
`timescale 1ns/1ps

module sfdpr_rom #(
	parameter logic [7:0] MFR_ID = 8'h5C
) (
	input wire logic [sfdpr_pkg::SPACE_AW-1:0] addr_i,
	output logic [7:0] data_o
);

	// There is no write port at all, so no command can alter the contents.
	always_comb begin
		data_o = sfdpr_pkg::ERASED_BYTE;
		if (addr_i == sfdpr_pkg::PH0_MFR_ADDR || addr_i == sfdpr_pkg::PH1_MFR_ADDR) begin
			data_o = MFR_ID;
		end else if (int'(addr_i) < sfdpr_pkg::HDR_LEN) begin
			data_o = sfdpr_pkg::HDR_BYTES[int'(addr_i)];
		end else if (addr_i >= sfdpr_pkg::BASIC_BASE &&
			int'(addr_i - sfdpr_pkg::BASIC_BASE) < sfdpr_pkg::BASIC_LEN) begin
			data_o = sfdpr_pkg::BASIC_BYTES[int'(addr_i - sfdpr_pkg::BASIC_BASE)];
		end
	end

endmodule : sfdpr_rom

// File: rtl/sfdpr_top.sv
// Serial read of the discoverable-parameter space, with status in the reference clock domain.
// Assumes the host clocks the link with the serial clock only while chip select is low.
`timescale 1ns/1ps

// Operation
// - Parameter space is 2048 read-only bytes.
// - Unwritten bytes read as erased FFh.
// - Eight dummy clocks follow with output undriven.
// - Bytes stream out from the given address.
// - Output bits change on serial clock falling edge.
// - Chip select high stops output, drops state.
// - Header returns signature and revision bytes.
// - Header count byte 00h, reserved bytes FFh.
// - Headers carry fixed manufacturer byte.
// - First header: revision, length, pointer 80h.
// - Second header: length zero, pointer 90h.
// - Byte 80h returns E5h.
// - Byte 81h returns 20h, 83h FFh.
// - Byte 82h returns F1h.
// - Bytes 84h-87h encode array size.
// - Bytes 88h-89h describe quad I/O read.
// - Bytes 8Ah-8Bh describe quad output read.
// - Bytes 8Ch-8Dh describe dual output read.
// - Bytes 8Eh-8Fh describe dual I/O read.
// - Reserved table ranges read as FFh.
module sfdpr_top #(
	parameter logic [7:0] MFR_ID = 8'h5C,
	parameter int unsigned CNT_W = sfdpr_pkg::STAT_CNT_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire sfdpr_pkg::sfdpr_link_in_s link_i,
	output sfdpr_pkg::sfdpr_link_out_s link_o,
	input wire logic param_en_i,
	input wire logic err_clr_i,
	output sfdpr_pkg::sfdpr_status_s status_o
);

	// Link domain state.
	logic link_rst;
	logic en_meta_ff;
	logic en_ff;
	sfdpr_pkg::sfdpr_phase_e phase_ff;
	sfdpr_pkg::sfdpr_phase_e nxt_phase;
	logic [sfdpr_pkg::PHASE_CNT_W-1:0] cnt_ff;
	logic [sfdpr_pkg::PHASE_CNT_W-1:0] nxt_cnt;
	logic [7:0] cmd_ff;
	logic [7:0] nxt_cmd;
	logic [sfdpr_pkg::ADDR_BITS-1:0] addr_ff;
	logic [sfdpr_pkg::ADDR_BITS-1:0] nxt_addr;
	logic [sfdpr_pkg::SPACE_AW-1:0] rd_addr_ff;
	logic [sfdpr_pkg::SPACE_AW-1:0] nxt_rd_addr;
	logic [2:0] bit_idx_ff;
	logic [2:0] nxt_bit_idx;
	logic data_lvl_ff;
	logic bad_lvl_ff;
	logic byte_tgl_ff;
	logic miso_ff;
	logic miso_oe_ff;
	logic [7:0] rom_byte;
	logic [sfdpr_pkg::ADDR_BITS-1:0] addr_hold_ff;

	// Reference domain state.
	// Every crossing level resets low except chip select, which resets high; the byte toggle keeps its last level between frames.
	localparam logic [sfdpr_pkg::XS_W-1:0] XS_IDLE = sfdpr_pkg::XS_W'(1) << sfdpr_pkg::XS_CS;
	logic [sfdpr_pkg::XS_W-1:0] xs_meta_ff;
	logic [sfdpr_pkg::XS_W-1:0] xs_sync_ff;
	logic [sfdpr_pkg::XS_W-1:0] xs_prev_ff;
	logic byte_evt;
	logic act_rise;
	logic bad_rise;
	logic frame_end;
	logic byte_pulse_ff;
	logic bad_cmd_ff;
	logic [sfdpr_pkg::ADDR_BITS-1:0] start_addr_ff;
	logic [CNT_W-1:0] byte_count_ff;
	logic [CNT_W-1:0] frame_count_ff;
	logic [CNT_W-1:0] frame_bytes_ff;
	logic [CNT_W-1:0] last_frame_bytes_ff;

	// Deselect clears the whole command state at once, even with the serial clock stopped.
	assign link_rst = rst_i | link_i.cs_n;

	// The enable comes from the reference domain; it settles long before the command completes.
	always_ff @(posedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			en_meta_ff <= 1'b0;
			en_ff <= 1'b0;
		end else begin
			en_meta_ff <= param_en_i;
			en_ff <= en_meta_ff;
		end
	end

	always_comb begin
		nxt_phase = phase_ff;
		nxt_cnt = cnt_ff;
		nxt_cmd = cmd_ff;
		nxt_addr = addr_ff;
		nxt_rd_addr = rd_addr_ff;
		nxt_bit_idx = bit_idx_ff;
		case (phase_ff)
			sfdpr_pkg::PH_CMD: begin
				nxt_cmd = {cmd_ff[6:0], link_i.mosi};
				nxt_cnt = cnt_ff + 1'b1;
				if (cnt_ff == sfdpr_pkg::CMD_LAST) begin
					nxt_cnt = '0;
					// Any other code leaves the link idle until deselect.
					if (nxt_cmd == sfdpr_pkg::CMD_READ_PARAM && en_ff) begin
						nxt_phase = sfdpr_pkg::PH_ADDR;
					end else begin
						nxt_phase = sfdpr_pkg::PH_IGNORE;
					end
				end
			end
			sfdpr_pkg::PH_ADDR: begin
				nxt_addr = {addr_ff[sfdpr_pkg::ADDR_BITS-2:0], link_i.mosi};
				nxt_cnt = cnt_ff + 1'b1;
				if (cnt_ff == sfdpr_pkg::ADDR_LAST) begin
					nxt_cnt = '0;
					// Upper address bits fold onto the 2048-byte space.
					nxt_rd_addr = nxt_addr[sfdpr_pkg::SPACE_AW-1:0];
					nxt_phase = sfdpr_pkg::PH_DUMMY;
				end
			end
			sfdpr_pkg::PH_DUMMY: begin
				nxt_cnt = cnt_ff + 1'b1;
				if (cnt_ff == sfdpr_pkg::DUMMY_LAST) begin
					nxt_cnt = '0;
					nxt_bit_idx = '0;
					nxt_phase = sfdpr_pkg::PH_DATA;
				end
			end
			sfdpr_pkg::PH_DATA: begin
				nxt_bit_idx = bit_idx_ff + 1'b1;
				if (bit_idx_ff == sfdpr_pkg::BYTE_LAST_BIT) begin
					nxt_rd_addr = rd_addr_ff + 1'b1;
				end
			end
			sfdpr_pkg::PH_IGNORE: begin
				nxt_phase = sfdpr_pkg::PH_IGNORE;
			end
			default: begin
				nxt_phase = sfdpr_pkg::PH_IGNORE;
			end
		endcase
	end

	// Sequencing: the phase and the counters that pace it.
	always_ff @(posedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			phase_ff <= sfdpr_pkg::PH_CMD;
			cnt_ff <= '0;
			bit_idx_ff <= '0;
		end else begin
			phase_ff <= nxt_phase;
			cnt_ff <= nxt_cnt;
			bit_idx_ff <= nxt_bit_idx;
		end
	end

	// Shift registers and the read pointer.
	always_ff @(posedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			cmd_ff <= '0;
			addr_ff <= '0;
			rd_addr_ff <= '0;
		end else begin
			cmd_ff <= nxt_cmd;
			addr_ff <= nxt_addr;
			rd_addr_ff <= nxt_rd_addr;
		end
	end

	// The accepted address is held past deselect, so the reference side reads a still word.
	// It changes only at the end of the next address phase, long after the level has crossed.
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_hold_ff <= sfdpr_pkg::START_ADDR_RST;
		end else if (!link_i.cs_n && phase_ff == sfdpr_pkg::PH_ADDR &&
			cnt_ff == sfdpr_pkg::ADDR_LAST) begin
			addr_hold_ff <= nxt_addr;
		end
	end

	// Single flops for the crossing levels, so no decoder glitch reaches the synchroniser.
	always_ff @(posedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			data_lvl_ff <= 1'b0;
		end else begin
			data_lvl_ff <= (nxt_phase == sfdpr_pkg::PH_DATA);
		end
	end

	always_ff @(posedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			bad_lvl_ff <= 1'b0;
		end else begin
			bad_lvl_ff <= (nxt_phase == sfdpr_pkg::PH_IGNORE);
		end
	end

	// The byte toggle survives deselect; clearing it there would fake an event.
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			byte_tgl_ff <= 1'b0;
		end else if (!link_i.cs_n && phase_ff == sfdpr_pkg::PH_DATA &&
			bit_idx_ff == sfdpr_pkg::BYTE_LAST_BIT) begin
			byte_tgl_ff <= ~byte_tgl_ff;
		end
	end

	sfdpr_rom #(
		.MFR_ID(MFR_ID)
	) u_rom (
		.addr_i(rd_addr_ff),
		.data_o(rom_byte)
	);

	// Output launches on the falling edge, giving the host a half period before it samples.
	always_ff @(negedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			miso_oe_ff <= 1'b0;
		end else begin
			miso_oe_ff <= (phase_ff == sfdpr_pkg::PH_DATA);
		end
	end

	always_ff @(negedge sclk_i or posedge link_rst) begin
		if (link_rst) begin
			miso_ff <= 1'b0;
		end else begin
			miso_ff <= rom_byte[sfdpr_pkg::BYTE_LAST_BIT - bit_idx_ff];
		end
	end

	assign link_o.miso = miso_ff;
	assign link_o.miso_oe = miso_oe_ff;

	// Two-flop synchronisers into the reference domain; only the second stage is read.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			xs_meta_ff <= XS_IDLE;
			xs_sync_ff <= XS_IDLE;
		end else begin
			xs_meta_ff[sfdpr_pkg::XS_ACTIVE] <= data_lvl_ff;
			xs_meta_ff[sfdpr_pkg::XS_BAD] <= bad_lvl_ff;
			xs_meta_ff[sfdpr_pkg::XS_TGL] <= byte_tgl_ff;
			xs_meta_ff[sfdpr_pkg::XS_CS] <= link_i.cs_n;
			xs_sync_ff <= xs_meta_ff;
		end
	end

	// Starting from the idle levels keeps a false frame end out of the first cycles after reset.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			xs_prev_ff <= XS_IDLE;
		end else begin
			xs_prev_ff <= xs_sync_ff;
		end
	end

	assign byte_evt = xs_sync_ff[sfdpr_pkg::XS_TGL] ^ xs_prev_ff[sfdpr_pkg::XS_TGL];
	assign act_rise = xs_sync_ff[sfdpr_pkg::XS_ACTIVE] & ~xs_prev_ff[sfdpr_pkg::XS_ACTIVE];
	assign bad_rise = xs_sync_ff[sfdpr_pkg::XS_BAD] & ~xs_prev_ff[sfdpr_pkg::XS_BAD];
	assign frame_end = xs_sync_ff[sfdpr_pkg::XS_CS] & ~xs_prev_ff[sfdpr_pkg::XS_CS];

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			byte_pulse_ff <= 1'b0;
		end else begin
			byte_pulse_ff <= byte_evt;
		end
	end

	// A new refusal in the clearing cycle still leaves the flag set.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bad_cmd_ff <= 1'b0;
		end else if (bad_rise) begin
			bad_cmd_ff <= 1'b1;
		end else if (err_clr_i) begin
			bad_cmd_ff <= 1'b0;
		end
	end

	// The held address is still when the synchronised data level rises, so one sample is safe.
	// A frame shorter than one reference cycle of data may leave it unsampled.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			start_addr_ff <= sfdpr_pkg::START_ADDR_RST;
		end else if (act_rise) begin
			start_addr_ff <= addr_hold_ff;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			byte_count_ff <= CNT_W'(sfdpr_pkg::STAT_CNT_RST);
		end else if (byte_evt) begin
			byte_count_ff <= byte_count_ff + 1'b1;
		end
	end

	// Bytes of the running frame.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_bytes_ff <= CNT_W'(sfdpr_pkg::STAT_CNT_RST);
		end else if (frame_end) begin
			frame_bytes_ff <= CNT_W'(sfdpr_pkg::STAT_CNT_RST);
		end else if (byte_evt) begin
			frame_bytes_ff <= frame_bytes_ff + 1'b1;
		end
	end

	// A byte ending in the same cycle as the frame is still counted for that frame.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			last_frame_bytes_ff <= CNT_W'(sfdpr_pkg::STAT_CNT_RST);
		end else if (frame_end) begin
			last_frame_bytes_ff <= frame_bytes_ff + CNT_W'(byte_evt);
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_count_ff <= CNT_W'(sfdpr_pkg::STAT_CNT_RST);
		end else if (frame_end) begin
			frame_count_ff <= frame_count_ff + 1'b1;
		end
	end

	assign status_o.active = xs_sync_ff[sfdpr_pkg::XS_ACTIVE];
	assign status_o.byte_pulse = byte_pulse_ff;
	assign status_o.bad_cmd = bad_cmd_ff;
	assign status_o.start_addr = start_addr_ff;
	assign status_o.byte_count = sfdpr_pkg::STAT_CNT_W'(byte_count_ff);
	assign status_o.frame_count = sfdpr_pkg::STAT_CNT_W'(frame_count_ff);
	assign status_o.last_frame_bytes = sfdpr_pkg::STAT_CNT_W'(last_frame_bytes_ff);

endmodule : sfdpr_top
